/* File: core/bche_pkg.sv */
// Behaviour
// - sector size 512 or 1024 bytes, one setting for all sectors of the page
// - write computes redundancy words per sector
// - read computes remainders; nonzero means corrupted
// - corrupted sector raises interrupt, status names it
// - valid redundancy words follow capability code
// - valid redundancy bytes follow code, LSB first
// - protected spare encoded with last sector
// - unprotected write excludes spare, data start
// - valid remainder words follow capability code
// - programmed ECC area skipped while decoding with spare protection on
// - locator accelerator may read results
// - one, two, four or eight sectors
// - strengths 2, 4, 8, 12, 24 bits
// - auto retrieval takes ECC during read when spare protection is off
//
// constants, types and tables of the sector ECC engine
// assumes a classic wishbone slave with 32-bit data
package bche_pkg;
    localparam int LANES = 12;
    localparam int SLOTS = 16;
    localparam int MEM_AW = 7;
    localparam logic [9:0] ADDR_CFG = 10'h000;
    localparam logic [9:0] ADDR_SAREA = 10'h004;
    localparam logic [9:0] ADDR_SADDR = 10'h008;
    localparam logic [9:0] ADDR_EADDR = 10'h00C;
    localparam logic [9:0] ADDR_CTRL = 10'h014;
    localparam logic [9:0] ADDR_SR = 10'h018;
    localparam logic [9:0] ADDR_ISR = 10'h028;
    localparam logic [1:0] ADDR_MEM_TOP = 2'h2;
    localparam int CFG_CAP = 0;
    localparam int CFG_SEC1K = 4;
    localparam int CFG_NSEC = 8;
    localparam int CFG_WRDIR = 12;
    localparam int CFG_SPARE = 16;
    localparam int CFG_AUTO = 20;
    localparam int CTRL_RST = 0;
    localparam int CTRL_DATA = 1;
    localparam int CTRL_USER = 2;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [10:0] SEC_BYTES_512 = 11'h200;
    localparam logic [10:0] SEC_BYTES_1K = 11'h400;
    // lane polynomials, arbitrary stand-ins for the minimal polynomials
    localparam logic [31:0] LANE_POLY [0:11] = '{
        32'h04C1_1DB7, 32'h1EDC_6F41, 32'h741B_8CD7, 32'h8141_AB71,
        32'hA833_982B, 32'h32C0_0699, 32'hF4AC_FB13, 32'h5D6D_CB65,
        32'h9960_034D, 32'h2F3C_D1A9, 32'hC8DF_352F, 32'h6B37_A4D3};

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_DATA = 8'h02,
        ST_SPARE = 8'h04,
        ST_SAVE = 8'h08,
        ST_WAITUSR = 8'h10,
        ST_ECCRD = 8'h20,
        ST_ECCWR = 8'h40,
        ST_SCAN = 8'h80
    } bche_state_t;

    function automatic logic [3:0] red_words(input logic [2:0] cap, input logic k1);
        case (cap)
            3'h0: red_words = 4'h1;
            3'h1: red_words = 4'h2;
            3'h2: red_words = 4'h4;
            3'h3: red_words = 4'h7;
            3'h4: red_words = k1 ? 4'hB : 4'hA;
            default: red_words = 4'h0;
        endcase
    endfunction

    function automatic logic [3:0] rem_words(input logic [2:0] cap);
        case (cap)
            3'h0: rem_words = 4'h1;
            3'h1: rem_words = 4'h2;
            3'h2: rem_words = 4'h4;
            3'h3: rem_words = 4'h8;
            3'h4: rem_words = 4'hC;
            default: rem_words = 4'h0;
        endcase
    endfunction

    function automatic logic [5:0] ecc_bytes(input logic [2:0] cap, input logic k1);
        case (cap)
            3'h0: ecc_bytes = 6'h04;
            3'h1: ecc_bytes = 6'h07;
            3'h2: ecc_bytes = k1 ? 6'h0E : 6'h0D;
            3'h3: ecc_bytes = k1 ? 6'h15 : 6'h14;
            3'h4: ecc_bytes = k1 ? 6'h2A : 6'h27;
            default: ecc_bytes = 6'h00;
        endcase
    endfunction

    function automatic logic [4:0] strength(input logic [2:0] cap);
        case (cap)
            3'h0: strength = 5'h02;
            3'h1: strength = 5'h04;
            3'h2: strength = 5'h08;
            3'h3: strength = 5'h0C;
            3'h4: strength = 5'h18;
            default: strength = 5'h00;
        endcase
    endfunction

    function automatic logic [31:0] crc_byte(input logic [31:0] s, input logic [7:0] d, input logic [31:0] p);
        logic [31:0] v;
        v = s;
        for (int i = 7; i >= 0; i--)
        begin
            v = (v[31] ^ d[i]) ? ((v << 1) ^ p) : (v << 1);
        end
        crc_byte = v;
    endfunction
endpackage

/* File: core/bche_wordmem.sv */
// per-sector word store with registered read data
// assumes one write and one read port on the same clock
`timescale 1ns/1ps
module bche_wordmem #(
    parameter int WIDTH = 32,
    parameter int AW = 7
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // write port
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    // read port
    input wire logic [AW-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);
    logic [WIDTH-1:0] store [0:(1<<AW)-1];

    always_ff @(posedge clk)
    begin
        if (wrEn)
        begin
            store[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdData <= '0;
        end
        else
        begin
            rdData <= store[rdAddr];
        end
    end
endmodule // bche_wordmem

/* File: core/bche_engine.sv */
// sector ECC engine: stream encoder and remainder generator with wishbone registers
// assumes the byte stream and its page offset arrive on clk from the memory controller
`timescale 1ns/1ps
module bche_engine #(
    parameter int PAGE_AW = 14
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // nand byte stream
    input wire logic strmValid,
    input wire logic [7:0] strmData,
    input wire logic [PAGE_AW-1:0] strmAddr,
    output logic strmReady,
    // corrupted sector event
    output logic sectorErrIrq
);
    localparam int LN = bche_pkg::LANES;

    bche_pkg::bche_state_t stateFf;
    bche_pkg::bche_state_t nxt_state;
    logic [2:0] capFf;
    logic sec1kFf;
    logic [1:0] nsecFf;
    logic writeDirectionSelFf;
    logic spareProtectEnFf;
    logic autoFf;
    logic [8:0] sareaFf;
    logic [PAGE_AW-1:0] saddrFf;
    logic [PAGE_AW-1:0] eaddrFf;
    logic [31:0] lfsrFf [0:LN-1];
    logic [2:0] secFf;
    logic [10:0] byteFf;
    logic [3:0] laneFf;
    logic [5:0] eccIdxFf;
    logic [7:0] latchFf;
    logic [7:0] scanFf;
    logic scanVldFf;
    logic [2:0] scanSecFf;
    logic [7:0] isrFf;
    logic [7:0] doneFf;
    logic ackFf;
    logic pendFf;
    logic [31:0] datFf;
    logic readyFf;
    logic irqFf;

    // bus decode
    wire req = wb_cyc_i & wb_stb_i & ~ackFf;
    wire memWin = (wb_adr_i[9:8] == bche_pkg::ADDR_MEM_TOP) | (wb_adr_i[9:8] == 2'h3);
    wire wrStb = req & wb_we_i & ~pendFf;
    wire rdStb = req & ~wb_we_i;
    wire memRdReq = rdStb & memWin;
    wire memFree = (stateFf == bche_pkg::ST_IDLE) | (stateFf == bche_pkg::ST_WAITUSR);
    wire memIssue = memRdReq & memFree & ~pendFf;
    wire regAck = req & ~pendFf & ~memRdReq;
    wire cfgWr = wrStb & (wb_adr_i == bche_pkg::ADDR_CFG);
    wire sareaWr = wrStb & (wb_adr_i == bche_pkg::ADDR_SAREA);
    wire saddrWr = wrStb & (wb_adr_i == bche_pkg::ADDR_SADDR);
    wire eaddrWr = wrStb & (wb_adr_i == bche_pkg::ADDR_EADDR);
    wire ctrlWr = wrStb & (wb_adr_i == bche_pkg::ADDR_CTRL) & wb_sel_i[0];
    wire ctrlRst = ctrlWr & wb_dat_i[bche_pkg::CTRL_RST];
    wire ctrlData = ctrlWr & wb_dat_i[bche_pkg::CTRL_DATA] & ~ctrlRst;
    wire ctrlUser = ctrlWr & wb_dat_i[bche_pkg::CTRL_USER] & ~ctrlRst;
    wire isrRd = rdStb & (wb_adr_i == bche_pkg::ADDR_ISR);
    wire clrPage = ctrlData | ctrlRst;

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        for (int b = 0; b < 4; b++)
        begin
            old[8*b +: 8] = sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
        end
        merge = old;
    endfunction

    wire [31:0] cfgWord = {11'h000, autoFf, 3'h0, spareProtectEnFf, 3'h0, writeDirectionSelFf,
                           2'h0, nsecFf, 3'h0, sec1kFf, 1'b0, capFf};
    wire [31:0] cfgNew = merge(cfgWord, wb_dat_i, wb_sel_i);
    wire [31:0] sareaNew = merge({23'h0, sareaFf}, wb_dat_i, wb_sel_i);
    wire [31:0] saddrNew = merge({{(32-PAGE_AW){1'b0}}, saddrFf}, wb_dat_i, wb_sel_i);
    wire [31:0] eaddrNew = merge({{(32-PAGE_AW){1'b0}}, eaddrFf}, wb_dat_i, wb_sel_i);

    // state decode
    wire isData = stateFf == bche_pkg::ST_DATA;
    wire isSpare = stateFf == bche_pkg::ST_SPARE;
    wire isSave = stateFf == bche_pkg::ST_SAVE;
    wire isEccRd = stateFf == bche_pkg::ST_ECCRD;
    wire isEccWr = stateFf == bche_pkg::ST_ECCWR;
    wire isScan = stateFf == bche_pkg::ST_SCAN;

    wire [10:0] secBytes = sec1kFf ? bche_pkg::SEC_BYTES_1K : bche_pkg::SEC_BYTES_512;
    wire [3:0] nSec = 4'h1 << nsecFf;
    wire lastSec = {1'b0, secFf} == (nSec - 4'h1);
    wire [3:0] redWords = bche_pkg::red_words(capFf, sec1kFf);
    wire [3:0] remWords = bche_pkg::rem_words(capFf);
    wire [5:0] eccBytes = bche_pkg::ecc_bytes(capFf, sec1kFf);
    wire [4:0] tBits = bche_pkg::strength(capFf);
    wire [3:0] validWords = writeDirectionSelFf ? redWords : remWords;

    wire accept = strmValid & readyFf;
    wire inSkip = ~writeDirectionSelFf & spareProtectEnFf & (strmAddr >= saddrFf) & (strmAddr <= eaddrFf);
    wire absorb = accept & (isData | isSpare) & ~inSkip;
    wire dataEnd = accept & isData & (byteFf == secBytes - 11'h001);
    wire spareEnd = accept & isSpare & (byteFf == {2'h0, sareaFf} - 11'h001);
    wire toSpare = lastSec & spareProtectEnFf & (sareaFf != 9'h000);
    wire laneEnd = isSave & (laneFf == 4'(LN - 1));
    wire eccByteEnd = isEccWr & (eccIdxFf == eccBytes - 6'h01);
    wire scanEnd = isScan & scanFf[7];

    logic [3:0] saveByteEn;
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++)
        begin : g_bytes
            assign saveByteEn[gb] = {laneFf, 2'(gb)} < eccBytes;
        end
    endgenerate
    wire [31:0] saveMask = {{8{saveByteEn[3]}}, {8{saveByteEn[2]}}, {8{saveByteEn[1]}}, {8{saveByteEn[0]}}};
    wire laneValid = laneFf < validWords;
    wire [31:0] saveWord = laneValid ? (lfsrFf[laneFf] & saveMask) : 32'h0000_0000;

    // memory ports
    wire [6:0] eccAddr = {secFf, eccIdxFf[5:2]};
    wire [6:0] busMemAddr = wb_adr_i[8:2];
    wire [31:0] memRd;
    wire [31:0] eccShift = {24'h000000, latchFf} << {eccIdxFf[1:0], 3'b000};
    wire memWe = isSave | isEccWr;
    wire [6:0] memWa = isSave ? {secFf, laneFf} : eccAddr;
    wire [31:0] memWd = isSave ? saveWord : (memRd ^ eccShift);
    wire [6:0] memRa = (isEccRd | isEccWr) ? eccAddr : (isScan ? scanFf[6:0] : busMemAddr);

    bche_wordmem #(
        .WIDTH(32),
        .AW(bche_pkg::MEM_AW)
    ) u_mem (
        .clk(clk),
        .nrst(nrst),
        .wrEn(memWe),
        .wrAddr(memWa),
        .wrData(memWd),
        .rdAddr(memRa),
        .rdData(memRd)
    );

    wire scanHit = isScan & ~scanFf[7] & (scanFf[3:0] < remWords) & ({1'b0, scanFf[6:4]} < nSec);
    wire [7:0] isrSet = (scanVldFf & (memRd != 32'h0000_0000)) ? (8'h01 << scanSecFf) : 8'h00;
    wire [7:0] nxt_isr = (isrFf & (isrRd ? 8'h00 : 8'hFF) & (clrPage ? 8'h00 : 8'hFF)) | isrSet;
    wire [31:0] memVal = doneFf[wb_adr_i[8:6]] ? memRd : 32'h0000_0000;

    wire busy = ~(memFree | (stateFf == bche_pkg::ST_IDLE));
    wire [31:0] srWord = {12'h000, 1'b0, secFf, 3'h0, tBits, 5'h00, isScan, stateFf == bche_pkg::ST_WAITUSR,
                          busy};
    wire [31:0] regRd = (wb_adr_i == bche_pkg::ADDR_CFG) ? cfgWord :
                        (wb_adr_i == bche_pkg::ADDR_SAREA) ? {23'h0, sareaFf} :
                        (wb_adr_i == bche_pkg::ADDR_SADDR) ? {{(32-PAGE_AW){1'b0}}, saddrFf} :
                        (wb_adr_i == bche_pkg::ADDR_EADDR) ? {{(32-PAGE_AW){1'b0}}, eaddrFf} :
                        (wb_adr_i == bche_pkg::ADDR_SR) ? srWord :
                        (wb_adr_i == bche_pkg::ADDR_ISR) ? {24'h0, isrFf} : 32'h0000_0000;

    // sequencing
    always_comb
    begin
        nxt_state = stateFf;
        case (stateFf)
            bche_pkg::ST_IDLE:
            begin
                if (ctrlData)
                begin
                    nxt_state = bche_pkg::ST_DATA;
                end
            end
            bche_pkg::ST_DATA:
            begin
                if (dataEnd)
                begin
                    nxt_state = toSpare ? bche_pkg::ST_SPARE : bche_pkg::ST_SAVE;
                end
            end
            bche_pkg::ST_SPARE:
            begin
                if (spareEnd)
                begin
                    nxt_state = bche_pkg::ST_SAVE;
                end
            end
            bche_pkg::ST_SAVE:
            begin
                if (laneEnd & ~lastSec)
                begin
                    nxt_state = bche_pkg::ST_DATA;
                end
                else if (laneEnd & writeDirectionSelFf)
                begin
                    nxt_state = bche_pkg::ST_IDLE;
                end
                else if (laneEnd)
                begin
                    nxt_state = (autoFf & ~spareProtectEnFf) ? bche_pkg::ST_ECCRD : bche_pkg::ST_WAITUSR;
                end
            end
            bche_pkg::ST_WAITUSR:
            begin
                if (ctrlUser)
                begin
                    nxt_state = bche_pkg::ST_ECCRD;
                end
                else if (ctrlData)
                begin
                    nxt_state = bche_pkg::ST_DATA;
                end
            end
            bche_pkg::ST_ECCRD:
            begin
                if (accept)
                begin
                    nxt_state = bche_pkg::ST_ECCWR;
                end
            end
            bche_pkg::ST_ECCWR:
            begin
                nxt_state = (eccByteEnd & lastSec) ? bche_pkg::ST_SCAN : bche_pkg::ST_ECCRD;
            end
            bche_pkg::ST_SCAN:
            begin
                if (scanEnd)
                begin
                    nxt_state = bche_pkg::ST_IDLE;
                end
            end
            default:
            begin
                nxt_state = bche_pkg::ST_IDLE;
            end
        endcase
        if (ctrlRst)
        begin
            nxt_state = bche_pkg::ST_IDLE;
        end
    end

    wire nxtTakes = (nxt_state == bche_pkg::ST_DATA) | (nxt_state == bche_pkg::ST_SPARE) |
                    (nxt_state == bche_pkg::ST_ECCRD);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            stateFf <= bche_pkg::ST_IDLE;
            readyFf <= 1'b0;
        end
        else
        begin
            stateFf <= nxt_state;
            readyFf <= nxtTakes;
        end
    end

    // configuration registers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            {autoFf, spareProtectEnFf, writeDirectionSelFf} <= 3'h0;
            {nsecFf, sec1kFf, capFf} <= 6'h00;
        end
        else if (cfgWr)
        begin
            spareProtectEnFf <= cfgNew[bche_pkg::CFG_SPARE];
            writeDirectionSelFf <= cfgNew[bche_pkg::CFG_WRDIR];
            autoFf <= cfgNew[bche_pkg::CFG_AUTO];
            nsecFf <= cfgNew[bche_pkg::CFG_NSEC +: 2];
            sec1kFf <= cfgNew[bche_pkg::CFG_SEC1K];
            capFf <= cfgNew[bche_pkg::CFG_CAP +: 3];
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sareaFf <= 9'h000;
            saddrFf <= '0;
            eaddrFf <= '0;
        end
        else
        begin
            sareaFf <= sareaWr ? sareaNew[8:0] : sareaFf;
            saddrFf <= saddrWr ? saddrNew[PAGE_AW-1:0] : saddrFf;
            eaddrFf <= eaddrWr ? eaddrNew[PAGE_AW-1:0] : eaddrFf;
        end
    end

    genvar gl;
    generate
        for (gl = 0; gl < LN; gl++)
        begin : g_lanes
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    lfsrFf[gl] <= 32'h0000_0000;
                end
                else if (clrPage | laneEnd)
                begin
                    lfsrFf[gl] <= 32'h0000_0000;
                end
                else if (absorb)
                begin
                    lfsrFf[gl] <= bche_pkg::crc_byte(lfsrFf[gl], strmData, bche_pkg::LANE_POLY[gl]);
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            byteFf <= 11'h000;
            laneFf <= 4'h0;
        end
        else
        begin
            byteFf <= (clrPage | dataEnd | spareEnd) ? 11'h000 : byteFf + {10'h000, accept & (isData | isSpare)};
            laneFf <= (clrPage | laneEnd) ? 4'h0 : laneFf + {3'h0, isSave};
        end
    end

    wire secStep = (laneEnd | eccByteEnd) & ~lastSec;
    wire secWrap = (laneEnd | eccByteEnd) & lastSec;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            secFf <= 3'h0;
            eccIdxFf <= 6'h00;
        end
        else
        begin
            secFf <= (clrPage | secWrap) ? 3'h0 : secFf + {2'h0, secStep};
            eccIdxFf <= (clrPage | eccByteEnd) ? 6'h00 : eccIdxFf + {5'h00, isEccWr};
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            latchFf <= 8'h00;
        end
        else if (accept & isEccRd)
        begin
            latchFf <= strmData;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            scanFf <= 8'h00;
            scanVldFf <= 1'b0;
            scanSecFf <= 3'h0;
        end
        else
        begin
            scanFf <= clrPage ? 8'h00 : scanFf + {7'h00, isScan & ~scanFf[7]};
            scanVldFf <= scanHit;
            scanSecFf <= scanFf[6:4];
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            doneFf <= 8'h00;
            isrFf <= 8'h00;
            irqFf <= 1'b0;
        end
        else
        begin
            doneFf <= clrPage ? 8'h00 : (doneFf | (laneEnd ? (8'h01 << secFf) : 8'h00));
            isrFf <= nxt_isr;
            irqFf <= nxt_isr != 8'h00;
        end
    end

    // bus answer
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ackFf <= 1'b0;
            pendFf <= 1'b0;
            datFf <= 32'h0000_0000;
        end
        else
        begin
            ackFf <= regAck | pendFf;
            pendFf <= memIssue;
            datFf <= pendFf ? memVal : (regAck ? regRd : datFf);
        end
    end

    assign wb_ack_o = ackFf;
    assign wb_dat_o = datFf;
    assign strmReady = readyFf;
    assign sectorErrIrq = irqFf;
endmodule // bche_engine

/* File: verif/bche_asserts.sv */
// port checks of the sector ECC engine
// assumes bind onto bche_engine, one clock
`timescale 1ns/1ps
module bche_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // event
    input wire logic sectorErrIrq
);
    logic [2:0] capCode_ff;
    wire logic req = wb_cyc_i && wb_stb_i;
    wire logic rdAck = wb_ack_o && !wb_we_i;
    wire logic clrAdr = wb_adr_i == bche_pkg::ADDR_ISR || wb_adr_i == bche_pkg::ADDR_CTRL;
    wire logic [4:0] strTab = capCode_ff == 3'h4 ? 5'h18 : capCode_ff == 3'h3 ? 5'h0C : 5'h02 << capCode_ff;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            capCode_ff <= 3'h0;
        else if (wb_ack_o && wb_we_i && wb_adr_i == bche_pkg::ADDR_CFG && wb_sel_i[0])
            capCode_ff <= wb_dat_i[2:0];
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    AST_ACK_REQ: assert property (wb_ack_o |-> req) else $error("ack without request");
    AST_REG_ACK: assert property (req && !wb_adr_i[9] && !wb_ack_o |=> wb_ack_o) else $error("late ack");
    AST_WIN_RD: assert property (
        $rose(wb_stb_i) && wb_adr_i[9] && !wb_we_i |=> !wb_ack_o ##[1:1000] wb_ack_o) else $error("window read");
    AST_UNMAP: assert property (rdAck && wb_adr_i == 10'h03C |-> wb_dat_o == 32'h0) else $error("unmapped");
    AST_IRQ_HOLD: assert property (
        sectorErrIrq && !(req && clrAdr) |=> sectorErrIrq) else $error("irq dropped");
    AST_ISR_IRQ: assert property (
        rdAck && wb_adr_i == bche_pkg::ADDR_ISR |-> (wb_dat_o[7:0] != 8'h00) == $past(sectorErrIrq, 1))
        else $error("status and irq differ");
    AST_SR_STR: assert property (
        rdAck && wb_adr_i == bche_pkg::ADDR_SR |-> wb_dat_o[12:8] == strTab) else $error("strength");
endmodule // bche_asserts

bind bche_engine bche_asserts chk (.*);

/* File: verif/bche_nand_model.sv */
// nand stream source sending queued bytes
// assumes the bench fills q before starting a page
`timescale 1ns/1ps
module bche_nand_model (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // stream
    input wire logic strmReady,
    output logic strmValid,
    output logic [7:0] strmData,
    output logic [13:0] strmAddr
);
    logic [7:0] q[$];
    integer seed = 32'hBA9965D4;
    logic go;
    // bytes leave in page order, held until taken
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            strmValid <= 1'b0;
            strmData <= 8'h00;
            strmAddr <= 14'h0000;
        end
        else
        begin
            if (strmValid && strmReady)
                void'(q.pop_front());
            strmAddr <= (strmValid && strmReady) ? strmAddr + 14'h0001 : (q.size() == 0 ? 14'h0000 : strmAddr);
            if ((strmValid && strmReady) || !strmValid)
            begin
                go = q.size() > 0 && $random(seed) % 4 != 0;
                strmValid <= go;
                strmData <= go ? q[0] : ~strmData;
            end
        end
    end
endmodule // bche_nand_model

/* File: verif/tb_top.sv */
// bench: page write, corrupted read, clean read
// assumes the engine and nand model share clk
`timescale 1ns/1ps
module tb_top;
    logic clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, strmValid, strmReady, sectorErrIrq;
    logic [9:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd, m;
    logic [7:0] strmData;
    logic [13:0] strmAddr;
    logic [7:0] red [8][48];
    logic [7:0] pg [8192];
    integer seed = 32'hBA9965D4;
    int badCount, checksDone, cap, k1, ns, t, sp;
    int st [5] = '{2, 4, 8, 12, 24};
    bche_engine dut (.*);
    bche_nand_model nandSrc (.*);
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic int eccLen(input int c, input int k);
        int tab [2][5] = '{'{4, 7, 13, 20, 39}, '{4, 7, 14, 21, 42}};
        return tab[k][c];
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp)
        begin
            badCount++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wb(input logic we, input logic [9:0] a, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do
            @(posedge clk);
        while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask
    task automatic runPage(input int wr, input int flip);
        int sz, n, s, j, b;
        sz = k1 ? 1024 : 512;
        for (s = 0; s < ns; s++)
            for (j = 0; j < sz; j++)
                nandSrc.q.push_back(pg[s * sz + j] ^ 8'(flip && s == ns - 1 && j == 5));
        // spare bytes follow the last sector
        for (j = 0; j < 16 * sp; j++)
            nandSrc.q.push_back(pg[j]);
        for (s = 0; s < ns && !wr; s++)
            for (j = 0; j < eccLen(cap, k1); j++)
                nandSrc.q.push_back(red[s][j]);
        wb(1, bche_pkg::ADDR_CFG, cap | k1 << 4 | $clog2(ns) << 8 | wr << 12 | sp << bche_pkg::CFG_SPARE |
           !flip << bche_pkg::CFG_AUTO);
        wb(1, bche_pkg::ADDR_CTRL, 32'h0000_0002);
        n = 0;
        do
        begin
            // user mode once the page is in
            if (rd[1])
                wb(1, bche_pkg::ADDR_CTRL, 32'h0000_0004);
            wb(0, bche_pkg::ADDR_SR, 0);
        end
        while (rd[2:0] !== 3'h0 && ++n < 20000);
        check(nandSrc.q.size(), 0);
        for (s = 0; s < 8; s++)
            for (j = 0; j < 12; j++)
            begin
                wb(0, 10'h200 + 10'(s * 64 + j * 4), 0);
                m = 32'h0;
                for (b = 0; b < 4; b++)
                begin
                    if (wr)
                        red[s][4 * j + b] = rd[8 * b +: 8];
                    if (4 * j + b >= eccLen(cap, k1) || s >= ns)
                        m[8 * b +: 8] = 8'hFF;
                end
                if (flip && s == ns - 1 && j == 0)
                    check(32'(rd == 0), 0);
                else
                    check(rd & (wr || (flip && s == ns - 1) ? m : 32'hFFFF_FFFF), 0);
            end
        check(32'(sectorErrIrq), 32'(flip));
        wb(0, bche_pkg::ADDR_ISR, 0);
        check(rd, flip ? 1 << (ns - 1) : 0);
        check(32'(sectorErrIrq), 0);
    endtask
    initial
    begin
        nrst = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 10'h000;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        foreach (st[i])
        begin
            wb(0, i == 4 ? 10'h03C : 10'(i * 4), 0);
            check(rd, 0);
        end
        for (cap = 0; cap < 5; cap++)
        begin
            wb(1, bche_pkg::ADDR_CFG, cap | 32'h0000_1100);
            wb(0, bche_pkg::ADDR_CFG, 0);
            check(rd, cap | 32'h0000_1100);
            wb(0, bche_pkg::ADDR_SR, 0);
            check(32'(rd[12:8]), st[cap]);
        end
        // spare size and an ECC area past the page
        wb(1, bche_pkg::ADDR_SAREA, 32'h0000_0010);
        wb(1, bche_pkg::ADDR_SADDR, 32'h0000_3FFF);
        wb(1, bche_pkg::ADDR_EADDR, 32'h0000_3FFF);
        wb(0, bche_pkg::ADDR_EADDR, 0);
        check(rd, 32'h0000_3FFF);
        $display("test 0 done");
        for (t = 0; t < 4; t++)
        begin
            ns = 1 << t;
            sp = t & 1;
            k1 = $random(seed) & 1;
            cap = $unsigned($random(seed)) % 5;
            foreach (pg[i])
                pg[i] = 8'($random(seed));
            runPage(1, 0);
            runPage(0, 1);
            runPage(0, 0);
            $display("test %0d done", t + 1);
        end
        giveVerdict();
    end
    initial
    begin
        #9000000;
        badCount++;
        giveVerdict();
    end
endmodule // tb_top
